// ---- hw/cifl_params.svh ----
`ifndef CIFL_PARAMS_SVH
`define CIFL_PARAMS_SVH
// Register byte offsets
`define CIFL_OFF_CTRL 12'h000
`define CIFL_OFF_STATUS 12'h004
`define CIFL_OFF_MASK 12'h008
`define CIFL_OFF_DBASE 12'h00C
`define CIFL_OFF_DLIMIT 12'h010
`define CIFL_OFF_PADDR 12'h014
`define CIFL_OFF_PCLK_RELOAD 12'h018
`define CIFL_OFF_PCLK_COUNT 12'h01C
`define CIFL_OFF_SAVED_PADDR 12'h020
`define CIFL_OFF_SAVED_CTX 12'h024
// Control register fields
`define CIFL_MODE_CORR 0
`define CIFL_MODE_UNCORR 1
`define CIFL_MODE_PRIV 2
`define CIFL_MODE_NORM_EXIT 3
`define CIFL_MODE_BOUNDS 4
`define CIFL_MODE_INTERVAL 5
`define CIFL_CTRL_SUPERVISOR 8
`define CIFL_CTRL_NATIVE 9
`define CIFL_CTRL_PCLK_RUN 10
`define CIFL_CTRL_WMASK 32'h0000_073F
`define CIFL_CTRL_RESET 32'h0000_0100
// Flag positions, shared by status, mask and saved flags
`define CIFL_FLG_CORR 0
`define CIFL_FLG_UNCORR 1
`define CIFL_FLG_PRIV 2
`define CIFL_FLG_NORM_EXIT 3
`define CIFL_FLG_BOUNDS 4
`define CIFL_FLG_INTERVAL 5
`define CIFL_NFLAGS 6
`define CIFL_SAVED_FLG_LSB 16
// Instruction parcel decode
`define CIFL_GH_PRIV 7'h01
`define CIFL_PARCEL_NORM_EXIT 16'h0800
`define CIFL_PARCEL_ERR_EXIT 16'h0000
// Program address widths
`define CIFL_PADDR_LEGACY_MASK 32'h00FF_FFFF
`define CIFL_PADDR_NATIVE_MASK 32'hFFFF_FFFF
`define CIFL_RESET_WORD 32'h0000_0000
`endif

// ---- hw/cifl_pkg.sv ----
`default_nettype none
package cifl_pkg;
   typedef struct packed {
      logic valid;
      logic [15:0] parcel;
   } cifl_issue_t;
   typedef struct packed {
      logic corr;
      logic uncorr;
   } cifl_memerr_t;
   typedef struct packed {
      logic valid;
      logic [31:0] word_addr;
   } cifl_dref_t;
   typedef struct packed {
      logic [29:0] word_addr;
      logic [1:0] parcel_sel;
   } cifl_fetch_t;
endpackage
`default_nettype wire

// ---- hw/cifl_top.sv ----
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "cifl_params.svh"
`default_nettype none
module cifl_top
   import cifl_pkg::*;
#(
   parameter logic [7:0] CPU_NUM = 8'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cifl_issue_t issue,
   input wire cifl_memerr_t mem_err,
   input wire cifl_dref_t dref,
   output cifl_fetch_t fetch,
   output logic priv_exec_ok,
   output logic priv_blocked,
   output logic exchange_req,
   output logic irq
);

   function automatic logic is_priv(input logic [15:0] parcel);
      is_priv = (parcel[15:9] == `CIFL_GH_PRIV) && (parcel[5:3] != 3'h0);
   endfunction

   function automatic logic [31:0] clip_paddr(input logic [31:0] a, input logic native);
      clip_paddr = a & (native ? `CIFL_PADDR_NATIVE_MASK : `CIFL_PADDR_LEGACY_MASK);
   endfunction

   logic [31:0] ctrl;
   logic [`CIFL_NFLAGS-1:0] status;
   logic [`CIFL_NFLAGS-1:0] mask;
   logic [31:0] dbase;
   logic [31:0] dlimit;
   logic [31:0] prog_addr;
   logic [31:0] pclk_reload;
   logic [31:0] pclk_count;
   logic [31:0] saved_paddr;
   logic [7:0] saved_cpu;
   logic [`CIFL_NFLAGS-1:0] saved_flags;

   logic [`CIFL_NFLAGS-1:0] ev;
   logic [`CIFL_NFLAGS-1:0] w1c;
   logic [`CIFL_NFLAGS-1:0] next_status;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_en;
   logic supervisor;
   logic native;
   logic pclk_zero;
   logic out_of_bounds;
   logic exit_issue;
   logic exch_start;

   assign supervisor = ctrl[`CIFL_CTRL_SUPERVISOR];
   assign native = ctrl[`CIFL_CTRL_NATIVE];
   assign wr_en = psel & penable & pready & pwrite;
   assign pclk_zero = ctrl[`CIFL_CTRL_PCLK_RUN] & (pclk_count == `CIFL_RESET_WORD);
   // Operand addresses carry no parcel bits, so the check is word-granular
   assign out_of_bounds = (dref.word_addr < dbase) || (dref.word_addr >= dlimit);
   assign exit_issue = issue.valid && ((issue.parcel == `CIFL_PARCEL_NORM_EXIT) ||
                                       (issue.parcel == `CIFL_PARCEL_ERR_EXIT));
   // Fetch address taken straight from the program address flops
   assign fetch.word_addr = prog_addr[31:2];
   assign fetch.parcel_sel = prog_addr[1:0];

   always_comb begin
      ev = '0;
      // Memory errors pass even in supervisor state
      ev[`CIFL_FLG_CORR] = mem_err.corr & ctrl[`CIFL_MODE_CORR];
      ev[`CIFL_FLG_UNCORR] = mem_err.uncorr & ctrl[`CIFL_MODE_UNCORR];
      ev[`CIFL_FLG_PRIV] = issue.valid & is_priv(issue.parcel) & ~supervisor &
                           ctrl[`CIFL_MODE_PRIV];
      ev[`CIFL_FLG_NORM_EXIT] = issue.valid & (issue.parcel == `CIFL_PARCEL_NORM_EXIT) &
                                ctrl[`CIFL_MODE_NORM_EXIT];
      ev[`CIFL_FLG_BOUNDS] = dref.valid & out_of_bounds & ctrl[`CIFL_MODE_BOUNDS] &
                             ~supervisor;
      ev[`CIFL_FLG_INTERVAL] = pclk_zero & ctrl[`CIFL_MODE_INTERVAL] &
                               ~supervisor;
   end

   always_comb begin
      w1c = '0;
      if (wr_en && (paddr == `CIFL_OFF_STATUS)) begin
         w1c = pwdata[`CIFL_NFLAGS-1:0];
      end
      // A new event wins over a clear in the same cycle
      next_status = (status & ~w1c) | ev;
   end

   // Exits always exchange, interrupts exchange when raised
   assign exch_start = exit_issue | (|ev);

   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      case (paddr)
         `CIFL_OFF_CTRL: begin
            rd_data = ctrl;
         end
         `CIFL_OFF_STATUS: begin
            rd_data[`CIFL_NFLAGS-1:0] = status;
         end
         `CIFL_OFF_MASK: begin
            rd_data[`CIFL_NFLAGS-1:0] = mask;
         end
         `CIFL_OFF_DBASE: begin
            rd_data = dbase;
         end
         `CIFL_OFF_DLIMIT: begin
            rd_data = dlimit;
         end
         `CIFL_OFF_PADDR: begin
            rd_data = prog_addr;
         end
         `CIFL_OFF_PCLK_RELOAD: begin
            rd_data = pclk_reload;
         end
         `CIFL_OFF_PCLK_COUNT: begin
            rd_data = pclk_count;
         end
         `CIFL_OFF_SAVED_PADDR: begin
            rd_data = saved_paddr;
         end
         `CIFL_OFF_SAVED_CTX: begin
            rd_data[7:0] = saved_cpu;
            rd_data[`CIFL_SAVED_FLG_LSB +: `CIFL_NFLAGS] = saved_flags;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Zero-wait slave: answer registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready & ~rd_hit;
         if (psel && !penable && !pready && !pwrite) begin
            prdata <= rd_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CIFL_CTRL_RESET;
         mask <= '0;
         dbase <= '0;
         dlimit <= '0;
         pclk_reload <= '0;
      end else if (wr_en) begin
         case (paddr)
            `CIFL_OFF_CTRL: begin
               ctrl <= pwdata & `CIFL_CTRL_WMASK;
            end
            `CIFL_OFF_MASK: begin
               mask <= pwdata[`CIFL_NFLAGS-1:0];
            end
            `CIFL_OFF_DBASE: begin
               dbase <= pwdata;
            end
            `CIFL_OFF_DLIMIT: begin
               dlimit <= pwdata;
            end
            `CIFL_OFF_PCLK_RELOAD: begin
               pclk_reload <= pwdata;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & mask);
      end
   end

   // Program address: software load wins over the parcel step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_addr <= '0;
      end else if (wr_en && (paddr == `CIFL_OFF_PADDR)) begin
         prog_addr <= clip_paddr(pwdata, native);
      end else if (issue.valid) begin
         prog_addr <= clip_paddr(prog_addr + 32'h0000_0001, native);
      end else begin
         prog_addr <= clip_paddr(prog_addr, native);
      end
   end

   // Interval counter reloads on reaching zero, so it fires periodically
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pclk_count <= '0;
      end else if (wr_en && (paddr == `CIFL_OFF_PCLK_RELOAD)) begin
         pclk_count <= pwdata;
      end else if (ctrl[`CIFL_CTRL_PCLK_RUN]) begin
         pclk_count <= pclk_zero ? pclk_reload : pclk_count - 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priv_exec_ok <= 1'b0;
         priv_blocked <= 1'b0;
      end else begin
         priv_exec_ok <= issue.valid & is_priv(issue.parcel) & supervisor;
         priv_blocked <= issue.valid & is_priv(issue.parcel) & ~supervisor;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exchange_req <= 1'b0;
         saved_paddr <= '0;
         saved_cpu <= '0;
         saved_flags <= '0;
      end else begin
         exchange_req <= exch_start;
         if (exch_start) begin
            saved_paddr <= prog_addr;
            saved_cpu <= CPU_NUM;
            saved_flags <= next_status;
         end
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_corr_flag_set: assert property (
      mem_err.corr && ctrl[`CIFL_MODE_CORR] |=> status[`CIFL_FLG_CORR] && irq == |(status & $past(mask))
   ) else $error("correctable flag not set");

   a_uncorr_flag_cause: assert property (
      $rose(status[`CIFL_FLG_UNCORR]) |-> $past(mem_err.uncorr && ctrl[`CIFL_MODE_UNCORR])
   ) else $error("uncorrectable flag set without enabled error");

   a_priv_flag_set: assert property (
      issue.valid && is_priv(issue.parcel) && !supervisor && ctrl[`CIFL_MODE_PRIV]
      |=> status[`CIFL_FLG_PRIV] && priv_blocked
   ) else $error("privileged flag not set");

   a_super_suppress: assert property (
      ($rose(status[`CIFL_FLG_BOUNDS]) || $rose(status[`CIFL_FLG_INTERVAL]))
      |-> !$past(supervisor)
   ) else $error("source not suppressed in supervisor state");

   a_priv_exec_gate: assert property (
      priv_exec_ok |-> $past(supervisor) && !priv_blocked
   ) else $error("privileged instruction ran outside supervisor state");

   a_exit_flag_set: assert property (
      issue.valid && issue.parcel == `CIFL_PARCEL_NORM_EXIT && ctrl[`CIFL_MODE_NORM_EXIT]
      |=> status[`CIFL_FLG_NORM_EXIT]
   ) else $error("normal exit flag not set");

   a_exit_exchange: assert property (
      issue.valid && issue.parcel == `CIFL_PARCEL_NORM_EXIT |=> exchange_req
   ) else $error("normal exit did not exchange");

   a_bounds_flag_set: assert property (
      dref.valid && out_of_bounds && ctrl[`CIFL_MODE_BOUNDS] && !supervisor
      |=> status[`CIFL_FLG_BOUNDS]
   ) else $error("bounds flag not set");

   // A reload write in the same cycle takes the written value instead
   a_interval_flag_set: assert property (
      pclk_zero && ctrl[`CIFL_MODE_INTERVAL] && !supervisor
      |=> status[`CIFL_FLG_INTERVAL] &&
          pclk_count == ($past(wr_en && (paddr == `CIFL_OFF_PCLK_RELOAD)) ?
                         $past(pwdata) : $past(pclk_reload))
   ) else $error("interval flag or reload missing");

   a_legacy_width: assert property (
      !native && $past(!native) |-> prog_addr[31:24] == 8'h00
   ) else $error("program address wider than legacy width");

   a_paddr_saved: assert property (
      exchange_req |-> saved_paddr == $past(prog_addr)
   ) else $error("program address not saved on exchange");

   a_cpu_saved: assert property (
      exchange_req |-> saved_cpu == CPU_NUM
   ) else $error("processor number not saved on exchange");

   a_corr_flag_cause: assert property (
      $rose(status[`CIFL_FLG_CORR]) |-> $past(mem_err.corr && ctrl[`CIFL_MODE_CORR])
   ) else $error("correctable flag set without enabled error");

   a_uncorr_flag_set: assert property (
      mem_err.uncorr && ctrl[`CIFL_MODE_UNCORR] |=> status[`CIFL_FLG_UNCORR]
   ) else $error("uncorrectable flag not set");

   a_priv_flag_cause: assert property (
      $rose(status[`CIFL_FLG_PRIV]) |-> $past(issue.valid && ctrl[`CIFL_MODE_PRIV])
   ) else $error("privileged flag set without enabled issue");

   a_super_bit_held: assert property (
      !(wr_en && (paddr == `CIFL_OFF_CTRL)) |=> $stable(supervisor)
   ) else $error("supervisor state changed without a control write");

   a_priv_super_quiet: assert property (
      $rose(status[`CIFL_FLG_PRIV]) |-> !$past(supervisor)
   ) else $error("privileged flag raised in supervisor state");

   a_err_exit_exchange: assert property (
      issue.valid && (issue.parcel == `CIFL_PARCEL_ERR_EXIT) |=> exchange_req
   ) else $error("error exit did not exchange");

   a_priv_outcome: assert property (
      issue.valid && is_priv(issue.parcel)
      |=> priv_exec_ok == $past(supervisor) && priv_blocked == !$past(supervisor)
   ) else $error("privileged instruction outcome wrong");

   a_exit_flag_cause: assert property (
      $rose(status[`CIFL_FLG_NORM_EXIT])
      |-> $past(issue.valid && ctrl[`CIFL_MODE_NORM_EXIT])
   ) else $error("normal exit flag set without enabled exit");

   a_bounds_flag_cause: assert property (
      $rose(status[`CIFL_FLG_BOUNDS]) |-> $past(dref.valid && ctrl[`CIFL_MODE_BOUNDS])
   ) else $error("bounds flag set without enabled reference");

   a_in_range_quiet: assert property (
      dref.valid && (dref.word_addr >= dbase) && (dref.word_addr < dlimit)
      |=> !$rose(status[`CIFL_FLG_BOUNDS])
   ) else $error("bounds flag raised for an in-range reference");

   a_interval_cause: assert property (
      $rose(status[`CIFL_FLG_INTERVAL]) |-> $past(pclk_zero && ctrl[`CIFL_MODE_INTERVAL])
   ) else $error("interval flag set without counter at zero");

   a_paddr_step: assert property (
      issue.valid && !(wr_en && (paddr == `CIFL_OFF_PADDR))
      |=> prog_addr == clip_paddr($past(prog_addr) + 32'h0000_0001, $past(native))
   ) else $error("program address did not step on issue");

endmodule // cifl_top
`default_nettype wire

// ---- sim/cifl_far_model.sv ----
`default_nettype none
module cifl_far_model
   import cifl_pkg::*;
(
   input wire logic pclk,
   output var cifl_issue_t issue,
   output var cifl_memerr_t mem_err,
   output var cifl_dref_t dref
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      issue = '0;
      mem_err = '0;
      dref = '0;
   end
   // Kind 0 correctable, 1 uncorrectable, 2 issued parcel, 3 operand reference
   task automatic fire(input int kind, input logic [31:0] val, input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      mem_err.corr <= kind == 0;
      mem_err.uncorr <= kind == 1;
      issue.valid <= kind == 2;
      issue.parcel <= kind == 2 ? val[15:0] : ~issue.parcel;
      dref.valid <= kind == 3;
      dref.word_addr <= kind == 3 ? val : ~dref.word_addr;
      @(posedge pclk);
      // Idle payloads flip so logic that ignores valid sees no stale match
      issue.valid <= 1'b0;
      issue.parcel <= ~issue.parcel;
      mem_err <= '0;
      dref.valid <= 1'b0;
      dref.word_addr <= ~dref.word_addr;
   endtask
endmodule // cifl_far_model
`default_nettype wire

// ---- sim/cifl_top_test.sv ----
`include "cifl_params.svh"
`default_nettype none
module cifl_top_test
   import cifl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CPU_ID = 8'h5A;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q, msk;
   logic pready, pslverr, priv_exec_ok, priv_blocked, exchange_req, irq, err;
   cifl_issue_t issue;
   cifl_memerr_t mem_err;
   cifl_dref_t dref;
   cifl_fetch_t fetch;
   int failures = 0;
   int tests_run = 0;
   int seed = 66;
   int n;
   logic [31:0] edges [4] = '{32'h0000_000F, 32'h0000_0010, 32'h0000_001F, 32'h0000_0020};

   always #25 pclk = ~pclk;

   cifl_top #(.CPU_NUM(CPU_ID)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .issue(issue), .mem_err(mem_err), .dref(dref),
      .fetch(fetch), .priv_exec_ok(priv_exec_ok), .priv_blocked(priv_blocked),
      .exchange_req(exchange_req), .irq(irq));
   cifl_far_model far (.pclk(pclk), .issue(issue), .mem_err(mem_err), .dref(dref));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         close_out();
      end
   endtask

   // Reference model: expected flag, exchange and side outputs for one event
   task automatic run_ev(input logic [31:0] c, input int kind, input logic [31:0] v);
      logic [31:0] e, p;
      logic pr, x;
      pr = kind == 2 && v[15:9] == 7'h01 && v[5:3] != 3'h0;
      case (kind)
         0: e = 32'(c[0]);
         1: e = 32'(c[1]) << 1;
         2: e = (v == 32'h0000_0800 && c[3]) ? 32'h08 : (pr && c[2] && !c[8]) ? 32'h04 : 32'h0;
         default: e = ((v < 32'h10 || v >= 32'h20) && c[4] && !c[8]) ? 32'h10 : 32'h0;
      endcase
      x = e != 0 || (kind == 2 && (v == 32'h0000_0800 || v == 32'h0000_0000));
      p = $random(seed) & 32'h00FF_FFF0;
      apb(1'b1, `CIFL_OFF_CTRL, c);
      apb(1'b1, `CIFL_OFF_MASK, msk);
      apb(1'b1, `CIFL_OFF_STATUS, 32'h0000_003F);
      apb(1'b1, `CIFL_OFF_PADDR, p);
      far.fire(kind, v, $random(seed) & 3);
      #1;
      check(32'(exchange_req), 32'(x));
      if (pr) check(32'({priv_exec_ok, priv_blocked}), 32'({c[8], ~c[8]}));
      @(posedge pclk);
      #1;
      check(32'(irq), 32'((e & msk) != 0));
      apb(1'b0, `CIFL_OFF_STATUS, 32'h0);
      check(q, e);
      apb(1'b0, `CIFL_OFF_PADDR, 32'h0);
      check(q, p + 32'(kind == 2));
      check({fetch.word_addr, fetch.parcel_sel}, p + 32'(kind == 2));
      if (x) begin
         apb(1'b0, `CIFL_OFF_SAVED_CTX, 32'h0);
         check(q, {10'h0, e[5:0], 8'h00, CPU_ID});
         apb(1'b0, `CIFL_OFF_SAVED_PADDR, 32'h0);
         check(q, p);
      end
   endtask

   initial begin
      msk = 32'h0000_003F;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CIFL_OFF_CTRL, 32'h0);
      check(q, 32'h0000_0100);
      apb(1'b0, 12'h100, 32'h0);
      check({31'h0, err}, 32'h0000_0001);
      check(q, 32'h0);
      apb(1'b1, `CIFL_OFF_DBASE, 32'h0000_0010);
      apb(1'b1, `CIFL_OFF_DLIMIT, 32'h0000_0020);
      run_ev(32'h0000_0101, 0, 32'h0);
      run_ev(32'h0000_0100, 0, 32'h0);
      run_ev(32'h0000_0102, 1, 32'h0);
      run_ev(32'h0000_0000, 1, 32'h0);
      run_ev(32'h0000_0004, 2, 32'h0000_0208);
      run_ev(32'h0000_0000, 2, 32'h0000_0238);
      run_ev(32'h0000_0004, 2, 32'h0000_0200);
      run_ev(32'h0000_0104, 2, 32'h0000_0208);
      run_ev(32'h0000_0008, 2, 32'h0000_0800);
      run_ev(32'h0000_0000, 2, 32'h0000_0800);
      run_ev(32'h0000_0000, 2, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         run_ev(i == 5 ? 32'h0000_0110 : 32'h0000_0010, 3,
            i < 4 ? edges[i] : $random(seed) & 32'h3F);
      end
      msk = 32'h0000_0037;
      run_ev(32'h0000_0108, 2, 32'h0000_0800);
      apb(1'b1, `CIFL_OFF_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `CIFL_OFF_CTRL, 32'h0);
      check(q, 32'h0000_073F);
      apb(1'b1, `CIFL_OFF_PADDR, 32'hFFFF_FFFF);
      apb(1'b0, `CIFL_OFF_PADDR, 32'h0);
      check(q, 32'hFFFF_FFFF);
      apb(1'b1, `CIFL_OFF_CTRL, 32'h0000_0100);
      apb(1'b0, `CIFL_OFF_PADDR, 32'h0);
      check(q, 32'h00FF_FFFF);
      apb(1'b1, `CIFL_OFF_PCLK_RELOAD, 32'h0000_0003);
      apb(1'b1, `CIFL_OFF_CTRL, 32'h0000_0420);
      n = 0;
      do begin
         apb(1'b0, `CIFL_OFF_STATUS, 32'h0);
         n++;
      end while (q[5] !== 1'b1 && n < 30);
      check(q & 32'h20, 32'h0000_0020);
      if (q[5] !== 1'b1) begin
         close_out();
      end
      // Supervisor state must hold the counter flag off even while it wraps
      apb(1'b1, `CIFL_OFF_CTRL, 32'h0000_0520);
      apb(1'b1, `CIFL_OFF_STATUS, 32'h0000_003F);
      repeat (12) @(posedge pclk);
      apb(1'b0, `CIFL_OFF_STATUS, 32'h0);
      check(q & 32'h20, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CIFL_OFF_CTRL, 32'h0);
      check(q, 32'h0000_0100);
      close_out();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      close_out();
   end
endmodule // cifl_top_test
`default_nettype wire
